// [ccms_pkg.sv]
// Shared constants and types for the clock multiplier and system clock selector
package ccms_pkg;
	// Multiplier control register location and reset value
	localparam logic [7:0] CCMS_CLOCK_MULTIPLIER_CONTROL_ADDR = 8'hBE;
	localparam logic [7:0] CCMS_CLOCK_MULTIPLIER_CONTROL_RESET = 8'h00;
	// Field positions inside the multiplier control register
	localparam int CCMS_EN_BIT = 7;
	localparam int CCMS_INIT_BIT = 6;
	localparam int CCMS_RDY_BIT = 5;
	localparam int CCMS_SEL_LSB = 0;
	localparam int CCMS_SEL_W = 2;
	// Multiplier input select codes
	localparam logic [1:0] CCMS_MSEL_INT_HALF = 2'h0;
	localparam logic [1:0] CCMS_MSEL_EXT = 2'h1;
	localparam logic [1:0] CCMS_MSEL_EXT_HALF = 2'h2;
	// System clock source codes
	localparam logic [1:0] CCMS_SYS_INT = 2'h0;
	localparam logic [1:0] CCMS_SYS_EXT = 2'h1;
	localparam logic [1:0] CCMS_SYS_MUL = 2'h2;
	localparam logic [1:0] CCMS_SYS_RSVD = 2'h3;
	// Multiplication factor and lock criteria
	localparam int CCMS_MULT_FACTOR = 4;
	localparam int CCMS_LOCK_PERIODS = 8;
	localparam int CCMS_PERIOD_W = 16;
	// External oscillator edges counted before crystal is called settled
	localparam int CCMS_XTAL_SETTLE_EDGES = 16;
	localparam int CCMS_XTAL_CNT_W = 8;
	// Multiplier lock states
	typedef enum logic [1:0] {CCMS_MUL_OFF, CCMS_MUL_MEASURE, CCMS_MUL_LOCKED} ccms_mul_state_t;
endpackage

// [ccms_tick_mult.sv]
// Tick-rate multiplier: measures the input tick period and emits FACTOR ticks per period
`timescale 1ns/10ps
module ccms_tick_mult import ccms_pkg::*; #(
	parameter int PERIOD_W = CCMS_PERIOD_W,
	parameter int LOCK_PERIODS = CCMS_LOCK_PERIODS,
	parameter int FACTOR = CCMS_MULT_FACTOR
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Control from the register
	input wire logic enable,
	input wire logic start,
	// Selected input tick
	input wire logic in_tick,
	// Results
	output logic out_tick,
	output logic ready
);
	ccms_mul_state_t state, next_state; // Lock state
	logic [PERIOD_W-1:0] period_cnt, next_period_cnt; // Cycles since last input tick
	logic [PERIOD_W-1:0] last_period, next_last_period; // Last measured period
	logic [PERIOD_W-1:0] sub_cnt, next_sub_cnt; // Cycles since last output tick
	logic [7:0] stable_cnt, next_stable_cnt; // Consecutive equal periods
	logic [7:0] slot_cnt, next_slot_cnt; // Spaced output ticks given since the edge tick this period
	logic next_out_tick; // Registered output tick
	logic [PERIOD_W-1:0] this_period; // Period ending at this input tick
	logic [PERIOD_W-1:0] quarter; // Spacing between output ticks

	assign this_period = PERIOD_W'(period_cnt + 1'b1);
	assign quarter = PERIOD_W'(last_period / PERIOD_W'(FACTOR));
	assign ready = (state == CCMS_MUL_LOCKED);

	// Next-state logic; disabling drops straight to off so ready clears
	always_comb begin
		next_state = state;
		next_period_cnt = period_cnt;
		next_last_period = last_period;
		next_sub_cnt = sub_cnt;
		next_stable_cnt = stable_cnt;
		next_slot_cnt = slot_cnt;
		next_out_tick = 1'b0;
		if (!enable) begin
			next_state = CCMS_MUL_OFF;
			next_period_cnt = '0;
			next_stable_cnt = '0;
		end else begin
			// Period counter saturates so a dead input is seen
			if (in_tick) begin
				next_period_cnt = '0;
			end else if (period_cnt != {PERIOD_W{1'b1}}) begin
				next_period_cnt = PERIOD_W'(period_cnt + 1'b1);
			end
			case (state)
				CCMS_MUL_OFF: begin
					if (start) begin
						next_state = CCMS_MUL_MEASURE;
						next_stable_cnt = '0;
					end
				end
				CCMS_MUL_MEASURE: begin
					if (in_tick) begin
						next_last_period = this_period;
						if (this_period == last_period) begin
							next_stable_cnt = 8'(stable_cnt + 1'b1);
						end else begin
							next_stable_cnt = '0;
						end
						// Lock after enough identical periods
						if (this_period == last_period && stable_cnt == 8'(LOCK_PERIODS - 1)) begin
							next_state = CCMS_MUL_LOCKED;
							next_sub_cnt = '0;
							next_slot_cnt = '0;
							next_out_tick = 1'b1;
						end
					end
				end
				CCMS_MUL_LOCKED: begin
					if (start) begin
						// Re-initialise on request
						next_state = CCMS_MUL_MEASURE;
						next_stable_cnt = '0;
					end else if (period_cnt == {PERIOD_W{1'b1}}) begin
						// Input lost: output no longer valid
						next_state = CCMS_MUL_MEASURE;
						next_stable_cnt = '0;
					end else if (in_tick) begin
						// Input edge starts a new group of output ticks
						next_last_period = this_period;
						next_sub_cnt = '0;
						next_slot_cnt = '0;
						next_out_tick = 1'b1;
					end else if (slot_cnt < 8'(FACTOR - 1)) begin
						// Space the remaining ticks evenly; period below 2*FACTOR crowds them
						if (PERIOD_W'(sub_cnt + 1'b1) >= quarter) begin
							next_sub_cnt = '0;
							next_slot_cnt = 8'(slot_cnt + 1'b1);
							next_out_tick = 1'b1;
						end else begin
							next_sub_cnt = PERIOD_W'(sub_cnt + 1'b1);
						end
					end
				end
				default: begin
					next_state = CCMS_MUL_OFF;
				end
			endcase
		end
	end

	// State registers
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state <= CCMS_MUL_OFF;
			period_cnt <= '0;
			last_period <= '0;
			sub_cnt <= '0;
			stable_cnt <= '0;
			slot_cnt <= '0;
			out_tick <= 1'b0;
		end else begin
			state <= next_state;
			period_cnt <= next_period_cnt;
			last_period <= next_last_period;
			sub_cnt <= next_sub_cnt;
			stable_cnt <= next_stable_cnt;
			slot_cnt <= next_slot_cnt;
			out_tick <= next_out_tick;
		end
	end
endmodule // ccms_tick_mult

// [ccms_clock_control.sv]
// Clock multiplier control register and glitch-free system clock source selector
`timescale 1ns/10ps
module ccms_clock_control import ccms_pkg::*; (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Special function register port
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_wdata,
	output logic [7:0] sfr_rdata,
	// Oscillator inputs, asynchronous square waves
	input wire logic int_osc_clk_pin,
	input wire logic ext_osc_clk_pin,
	// Oscillator control bits held elsewhere
	input wire logic int_osc_enable,
	input wire logic ext_osc_enable,
	input wire logic ext_crystal_mode,
	input wire logic [1:0] system_clock_source_field,
	// Status and clock tick outputs
	output logic crystal_valid_flag,
	output logic multiplier_ready,
	output logic [1:0] sys_clk_source_active,
	output logic sys_clk_tick,
	output logic ext_periph_tick,
	output logic mult_clk_tick
);
	// Synchronisers: stage 1, stage 2, and a delayed copy for edge finding
	logic [2:0] int_sync, next_int_sync;
	logic [2:0] ext_sync, next_ext_sync;
	logic int_tick; // Rising edge of enabled internal oscillator
	logic ext_tick; // Rising edge of enabled external oscillator
	// Divide-by-two stages
	logic int_half, next_int_half;
	logic ext_half, next_ext_half;
	logic int_half_tick; // Every second internal edge
	logic ext_half_tick; // Every second external edge
	// Control register fields
	logic multiplier_enable, next_multiplier_enable;
	logic multiplier_initialise, next_multiplier_initialise;
	logic [1:0] multiplier_input_select, next_multiplier_input_select;
	logic [7:0] next_sfr_rdata;
	logic reg_hit; // Access addresses the control register
	logic mul_start; // One-cycle initialisation request
	logic mul_in_tick; // Selected multiplier input
	// Crystal settling
	logic [CCMS_XTAL_CNT_W-1:0] xtal_cnt, next_xtal_cnt;
	logic next_crystal_valid_flag;
	// System clock selector
	logic [1:0] next_sys_clk_source_active;
	logic next_sys_clk_tick;
	logic next_ext_periph_tick;

	// Tick of the given source code; reserved code gives nothing
	function automatic logic ccms_pick(input logic [1:0] code, input logic t_int,
		input logic t_ext, input logic t_mul);
		case (code)
			CCMS_SYS_INT: ccms_pick = t_int;
			CCMS_SYS_EXT: ccms_pick = t_ext;
			CCMS_SYS_MUL: ccms_pick = t_mul;
			default: ccms_pick = 1'b0;
		endcase
	endfunction

	assign int_tick = int_sync[1] & ~int_sync[2] & int_osc_enable;
	assign ext_tick = ext_sync[1] & ~ext_sync[2] & ext_osc_enable;
	assign int_half_tick = int_tick & int_half;
	assign ext_half_tick = ext_tick & ext_half;
	assign reg_hit = (sfr_addr == CCMS_CLOCK_MULTIPLIER_CONTROL_ADDR);
	// Initialisation only counts once the multiplier is already enabled
	assign mul_start = sfr_wr & reg_hit & sfr_wdata[CCMS_INIT_BIT] & multiplier_enable;

	// Multiplier input mux
	always_comb begin
		case (multiplier_input_select)
			CCMS_MSEL_INT_HALF: mul_in_tick = int_half_tick;
			CCMS_MSEL_EXT: mul_in_tick = ext_tick;
			CCMS_MSEL_EXT_HALF: mul_in_tick = ext_half_tick;
			default: mul_in_tick = 1'b0;
		endcase
	end

	// Tick multiplier and lock detector
	ccms_tick_mult #(
		.PERIOD_W(CCMS_PERIOD_W),
		.LOCK_PERIODS(CCMS_LOCK_PERIODS),
		.FACTOR(CCMS_MULT_FACTOR)
	) u_mult (
		.clk(clk),
		.rst_b(rst_b),
		.enable(multiplier_enable),
		.start(mul_start),
		.in_tick(mul_in_tick),
		.out_tick(mult_clk_tick),
		.ready(multiplier_ready)
	);

	// Oscillator synchronisers and half-rate toggles
	always_comb begin
		next_int_sync = {int_sync[1:0], int_osc_clk_pin};
		next_ext_sync = {ext_sync[1:0], ext_osc_clk_pin};
		next_int_half = int_tick ? ~int_half : int_half;
		next_ext_half = ext_tick ? ~ext_half : ext_half;
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			int_sync <= 3'h0;
			ext_sync <= 3'h0;
			int_half <= 1'b0;
			ext_half <= 1'b0;
		end else begin
			int_sync <= next_int_sync;
			ext_sync <= next_ext_sync;
			int_half <= next_int_half;
			ext_half <= next_ext_half;
		end
	end

	// Control register write and registered read
	always_comb begin
		next_multiplier_enable = multiplier_enable;
		next_multiplier_initialise = multiplier_initialise;
		next_multiplier_input_select = multiplier_input_select;
		next_sfr_rdata = 8'h00;
		if (sfr_wr && reg_hit) begin
			// Writing zero disables and so clears ready
			next_multiplier_enable = sfr_wdata[CCMS_EN_BIT];
			next_multiplier_initialise = sfr_wdata[CCMS_INIT_BIT];
			next_multiplier_input_select = sfr_wdata[CCMS_SEL_LSB +: CCMS_SEL_W];
		end
		if (sfr_rd && reg_hit) begin
			// Unused bits read zero
			next_sfr_rdata[CCMS_EN_BIT] = multiplier_enable;
			next_sfr_rdata[CCMS_INIT_BIT] = multiplier_initialise;
			next_sfr_rdata[CCMS_RDY_BIT] = multiplier_ready;
			next_sfr_rdata[CCMS_SEL_LSB +: CCMS_SEL_W] = multiplier_input_select;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			multiplier_enable <= CCMS_CLOCK_MULTIPLIER_CONTROL_RESET[CCMS_EN_BIT];
			multiplier_initialise <= CCMS_CLOCK_MULTIPLIER_CONTROL_RESET[CCMS_INIT_BIT];
			multiplier_input_select <= CCMS_CLOCK_MULTIPLIER_CONTROL_RESET[CCMS_SEL_LSB +: CCMS_SEL_W];
			sfr_rdata <= 8'h00;
		end else begin
			multiplier_enable <= next_multiplier_enable;
			multiplier_initialise <= next_multiplier_initialise;
			multiplier_input_select <= next_multiplier_input_select;
			sfr_rdata <= next_sfr_rdata;
		end
	end

	// Crystal settling; RC and C modes need no start-up so are valid at once
	always_comb begin
		next_xtal_cnt = xtal_cnt;
		next_crystal_valid_flag = crystal_valid_flag;
		if (!ext_osc_enable) begin
			next_xtal_cnt = '0;
			next_crystal_valid_flag = 1'b0;
		end else if (!ext_crystal_mode) begin
			next_crystal_valid_flag = 1'b1;
		end else if (ext_tick && !crystal_valid_flag) begin
			if (xtal_cnt == CCMS_XTAL_CNT_W'(CCMS_XTAL_SETTLE_EDGES - 1)) begin
				next_crystal_valid_flag = 1'b1;
			end else begin
				next_xtal_cnt = CCMS_XTAL_CNT_W'(xtal_cnt + 1'b1);
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			xtal_cnt <= '0;
			crystal_valid_flag <= 1'b0;
		end else begin
			xtal_cnt <= next_xtal_cnt;
			crystal_valid_flag <= next_crystal_valid_flag;
		end
	end

	// System clock selector: a switch lands on an edge of the new source,
	// and may follow the last old-source tick by one cycle; no settle wait is imposed
	always_comb begin
		next_sys_clk_source_active = sys_clk_source_active;
		next_sys_clk_tick = ccms_pick(sys_clk_source_active, int_tick, ext_tick, mult_clk_tick);
		if (system_clock_source_field != sys_clk_source_active &&
			system_clock_source_field != CCMS_SYS_RSVD &&
			ccms_pick(system_clock_source_field, int_tick, ext_tick, mult_clk_tick)) begin
			next_sys_clk_source_active = system_clock_source_field;
			next_sys_clk_tick = 1'b1;
		end
		// Peripherals keep the external clock whatever drives the system
		next_ext_periph_tick = ext_tick;
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sys_clk_source_active <= CCMS_SYS_INT;
			sys_clk_tick <= 1'b0;
			ext_periph_tick <= 1'b0;
		end else begin
			sys_clk_source_active <= next_sys_clk_source_active;
			sys_clk_tick <= next_sys_clk_tick;
			ext_periph_tick <= next_ext_periph_tick;
		end
	end
endmodule // ccms_clock_control

// [ccms_osc_model.sv]
// Behavioural model of the internal and external oscillators feeding the clock block
`timescale 1ns/10ps
module ccms_osc_model #(
	parameter int INT_HALF = 800,
	parameter int EXT_HALF = 600
) (
	// Oscillator enables from the bench
	input wire logic int_en,
	input wire logic ext_en,
	// Square waves to the block
	output logic int_pin,
	output logic ext_pin
);
	// Internal wave; a fixed phase offset keeps it unrelated to clk edges
	initial begin
		int_pin = 1'b0;
		#37;
		forever #(INT_HALF) int_pin = int_en & ~int_pin;
	end
	// External wave; stands low while disabled, as a stopped oscillator would
	initial begin
		ext_pin = 1'b0;
		#53;
		forever #(EXT_HALF) ext_pin = ext_en & ~ext_pin;
	end
endmodule // ccms_osc_model

// [ccms_clock_control_chk.sv]
// Assertion checker for the clock multiplier and system clock selector
`timescale 1ns/10ps
module ccms_clock_control_chk (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Register port
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_wdata,
	input wire logic [7:0] sfr_rdata,
	// Oscillator controls
	input wire logic ext_osc_enable,
	input wire logic ext_crystal_mode,
	input wire logic [1:0] system_clock_source_field,
	// Status and ticks
	input wire logic crystal_valid_flag,
	input wire logic multiplier_ready,
	input wire logic [1:0] sys_clk_source_active,
	input wire logic sys_clk_tick,
	input wire logic mult_clk_tick
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	chk_rdata_idle: assert property (!$past(sfr_rd) |-> sfr_rdata == 8'h00)
		else $error("read data not idle");
	chk_ready_bit: assert property ($past(sfr_rd && sfr_addr == 8'hBE)
		|-> sfr_rdata[5:2] == {$past(multiplier_ready), 3'h0})
		else $error("ready bit or reserved bits wrong");
	chk_ready_drop: assert property (sfr_wr && sfr_addr == 8'hBE && !sfr_wdata[7]
		|-> ##[1:2] !multiplier_ready)
		else $error("ready stayed after disable");
	chk_src_rsvd: assert property (sys_clk_source_active != 2'h3)
		else $error("reserved source active");
	chk_switch_tick: assert property ($changed(sys_clk_source_active) |-> sys_clk_tick)
		else $error("switch without tick");
	chk_switch_req: assert property ($changed(sys_clk_source_active)
		|-> sys_clk_source_active == $past(system_clock_source_field))
		else $error("switched to unrequested source");
	chk_xtal_clear: assert property (!ext_osc_enable ##1 !ext_osc_enable
		|-> !crystal_valid_flag)
		else $error("crystal valid while disabled");
	chk_rc_valid: assert property ((ext_osc_enable && !ext_crystal_mode)[*2]
		|-> crystal_valid_flag)
		else $error("rc mode not valid");
	chk_mul_quiet: assert property (!multiplier_ready && !$past(multiplier_ready)
		|-> !mult_clk_tick)
		else $error("multiplier tick while unlocked");
	cov_lock: cover property ($rose(multiplier_ready));
	cov_ext: cover property (sys_clk_source_active == 2'h1);
	cov_mul: cover property (sys_clk_source_active == 2'h2);
endmodule // ccms_clock_control_chk
bind ccms_clock_control ccms_clock_control_chk u_chk (.clk, .rst_b, .sfr_addr, .sfr_wr,
	.sfr_rd, .sfr_wdata, .sfr_rdata, .ext_osc_enable, .ext_crystal_mode,
	.system_clock_source_field, .crystal_valid_flag, .multiplier_ready,
	.sys_clk_source_active, .sys_clk_tick, .mult_clk_tick);

// [tb_top.sv]
// Self-checking testbench for the clock multiplier and system clock selector
`timescale 1ns/10ps
module tb_top import ccms_pkg::*; ;
	logic clk = 1'b0, rst_b = 1'b0, sfr_wr = 1'b0, sfr_rd = 1'b0, rd_d = 1'b0;
	logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata;
	logic int_en = 1'b1, ext_en = 1'b0, xmode = 1'b0, ipin, epin;
	logic [1:0] src = 2'h0, act;
	logic xvalid, mrdy, sys_tick, ext_tick, mul_tick;
	logic [7:0] exp_q[$]; // Expected read data, oldest first
	logic [31:0] lf = 32'h168D;
	logic [15:0] n;
	int n_errors = 0, check_count = 0, i, s;
	int per[3] = '{32, 12, 24}; // Multiplier input period in clk cycles per select code
	logic [1:0] tbl[4] = '{2'h1, 2'h2, 2'h3, 2'h0};
	logic [1:0] want[4] = '{2'h1, 2'h2, 2'h2, 2'h0};
	always #50 clk = ~clk;
	ccms_osc_model osc (.int_en(int_en), .ext_en(ext_en), .int_pin(ipin), .ext_pin(epin));
	ccms_clock_control dut (.clk(clk), .rst_b(rst_b), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
		.sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .int_osc_clk_pin(ipin),
		.ext_osc_clk_pin(epin), .int_osc_enable(int_en), .ext_osc_enable(ext_en),
		.ext_crystal_mode(xmode), .system_clock_source_field(src),
		.crystal_valid_flag(xvalid), .multiplier_ready(mrdy), .sys_clk_source_active(act),
		.sys_clk_tick(sys_tick), .ext_periph_tick(ext_tick), .mult_clk_tick(mul_tick));
	function automatic logic [31:0] lfsr(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	task automatic check_val(input logic [15:0] got, input logic [15:0] exp, input string m);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1'b1;
		@(negedge clk);
		sfr_wr = 1'b0;
	endtask
	// Read strobe for one cycle; the monitor compares the answer one cycle later
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(negedge clk);
		sfr_addr = a;
		sfr_rd = 1'b1;
		exp_q.push_back(e);
		@(negedge clk);
		sfr_rd = 1'b0;
	endtask
	// Counts one kind of tick over a window; 0 multiplier, 1 external, 2 system
	task automatic count_win(input int cyc, input int k, output logic [15:0] c);
		c = 16'h0000;
		repeat (cyc) begin
			@(negedge clk);
			c = c + {15'h0000, (k == 0) ? mul_tick : (k == 1) ? ext_tick : sys_tick};
		end
	endtask
	// Read monitor: the answer stands only in the cycle after the strobe
	always @(posedge clk) rd_d <= sfr_rd;
	always @(negedge clk) begin
		if (rd_d) begin
			check_val({8'h00, sfr_rdata}, {8'h00, exp_q.pop_front()}, "read data");
		end
	end
	task automatic final_report();
		$display("checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// Watchdog sized well beyond the crystal wait plus three lock sequences
	initial begin
		#(100 * 40000);
		n_errors++;
		final_report();
	end
	initial begin
		repeat (6) @(negedge clk);
		rst_b = 1'b1;
		rd(CCMS_CLOCK_MULTIPLIER_CONTROL_ADDR, CCMS_CLOCK_MULTIPLIER_CONTROL_RESET);
		rd(8'h55, 8'h00);
		for (i = 0; i < 8; i++) begin
			lf = lfsr(lf);
			wr((lf[7:0] == 8'hBE) ? 8'hBD : lf[7:0], lf[15:8]);
		end
		rd(8'hBE, 8'h00);
		$display("test register access done");
		// Init from disabled must not start, and the reserved select never locks
		wr(8'hBE, 8'hFF);
		repeat (400) @(negedge clk);
		rd(8'hBE, 8'hC3);
		$display("test init from disabled done");
		ext_en = 1'b1;
		xmode = 1'b1;
		repeat (10000) @(negedge clk);
		check_val({15'h0, xvalid}, 16'h1, "crystal valid");
		for (s = 0; s < 3; s++) begin
			wr(8'hBE, 8'h00);
			repeat (2) @(negedge clk);
			check_val({15'h0, mrdy}, 16'h0, "ready after clear");
			wr(8'hBE, 8'(s));
			wr(8'hBE, 8'h80 | 8'(s));
			repeat (60) @(negedge clk);
			wr(8'hBE, 8'hC0 | 8'(s));
			for (i = 0; i < 3000 && mrdy !== 1'b1; i++) @(negedge clk);
			rd(8'hBE, 8'hE0 | 8'(s));
			count_win(4 * per[s], 0, n);
			check_val(n, 16'h0010, "multiplier ticks");
		end
		$display("test multiplier done");
		for (s = 0; s < 4; s++) begin
			src = tbl[s];
			if (s == 2) repeat (100) @(negedge clk);
			for (i = 0; i < 200 && act !== want[s]; i++) @(negedge clk);
			check_val({14'h0, act}, {14'h0, want[s]}, "active source");
		end
		count_win(160, 2, n);
		check_val(n, 16'h000A, "system ticks on internal");
		count_win(120, 1, n);
		check_val(n, 16'h000A, "peripheral ticks");
		// Park on external, stop the internal one, then re-enable and select it at once
		int_en = 1'b0;
		src = 2'h1;
		for (i = 0; i < 200 && act !== 2'h1; i++) @(negedge clk);
		check_val({14'h0, act}, 16'h0001, "external while internal off");
		int_en = 1'b1;
		src = 2'h0;
		// One internal period plus synchroniser delay, with no settling wait
		for (i = 0; i < 24 && act !== 2'h0; i++) @(negedge clk);
		check_val({14'h0, act}, 16'h0000, "internal right after enable");
		$display("test selector done");
		ext_en = 1'b0;
		repeat (2) @(negedge clk);
		check_val({15'h0, xvalid}, 16'h0, "valid after disable");
		xmode = 1'b0;
		ext_en = 1'b1;
		repeat (2) @(negedge clk);
		check_val({15'h0, xvalid}, 16'h1, "rc valid");
		wr(8'hBE, 8'h00);
		repeat (2) @(negedge clk);
		check_val({15'h0, mrdy}, 16'h0, "ready after disable");
		rd(8'hBE, 8'h00);
		repeat (2) @(negedge clk);
		$display("test oscillator flags done");
		final_report();
	end
endmodule // tb_top
